// ==== inc/wdru_pkg.sv ====
// Purpose: shared constants and types for the watchdog reload/unlock block
// Assumes: 32-bit Avalon-MM slave, byte addresses are four times the index
// Notes:   one clock domain; the watchdog oscillator arrives as a tick pulse
//
// Summary of operation
// - key register at FF0H is write-only
// - 55H then AAH unlocks the reload bytes
// - key writes only advance the unlock logic
// - locked reload bytes ignore all writes
// - key address reads return reset-cause register
// - refresh copies 24-bit reload into counter
// - upper 23:16, middle 15:8, low 7:0
// - reads give live count, writes set reload
// - decrement per tick, time-out at zero
// - reload bytes written in order, else relock
// - time-out gives interrupt or reset, sets flag
// - refresh ignored once count is 000002H or less
package wdru_pkg;

    // register indices and the byte address width
    localparam logic [11:0] IDX_KEY    = 12'h0ff0;
    localparam logic [11:0] IDX_UPPER  = 12'h0ff1;
    localparam logic [11:0] IDX_MIDDLE = 12'h0ff2;
    localparam logic [11:0] IDX_LOW    = 12'h0ff3;
    localparam int          ADDR_W     = 14;

    // unlock key values
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // reload byte reset values
    localparam logic [7:0] RST_UPPER  = 8'h00;
    localparam logic [7:0] RST_MIDDLE = 8'h04;
    localparam logic [7:0] RST_LOW    = 8'h00;

    // counter thresholds
    localparam logic [23:0] REFRESH_FLOOR = 24'h00_0002;
    localparam logic [23:0] RELOAD_MIN    = 24'h00_0004;
    localparam logic [23:0] COUNT_LAST    = 24'h00_0001;

    // reset-cause register layout
    localparam logic [7:0] RC_RESET   = 8'h80;
    localparam int         RC_POR_BIT = 7;
    localparam int         RC_WDT_BIT = 5;

    // accepted register write, decoded
    typedef struct packed {
        logic       any;
        logic       key;
        logic       upper;
        logic       middle;
        logic       low;
        logic [7:0] data;
    } wdru_wr_s;

    // unlock sequencer states
    typedef enum logic [4:0] {
        U_LOCKED   = 5'b0_0001,
        U_KEY1     = 5'b0_0010,
        U_OPEN_UP  = 5'b0_0100,
        U_OPEN_MID = 5'b0_1000,
        U_OPEN_LOW = 5'b1_0000
    } wdru_unlock_e;

endpackage

// ==== core/wdru_unlock.sv ====
// Purpose: key sequence tracker that opens the reload bytes one at a time
// Assumes: wr carries one accepted register write per pulse
// Notes:   any write out of order drops back to locked, except a 55H key write, which goes to U_KEY1
`timescale 1ns/100ps
`default_nettype none
module wdru_unlock (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // decoded write
    input  wire wdru_pkg::wdru_wr_s wr,
    // write permissions
    output logic                   allow_upper,
    output logic                   allow_middle,
    output logic                   allow_low
);
    wdru_pkg::wdru_unlock_e state_reg;  // current state
    wdru_pkg::wdru_unlock_e state_next; // next state

    // next state on each write
    always_comb begin
        state_next = state_reg;
        if (wr.any) begin
            state_next = wdru_pkg::U_LOCKED; // stray write relocks
            if (wr.key && wr.data == wdru_pkg::KEY_FIRST) begin
                state_next = wdru_pkg::U_KEY1;
            end
            case (state_reg)
                wdru_pkg::U_LOCKED: begin
                end
                wdru_pkg::U_KEY1: begin
                    if (wr.key && wr.data == wdru_pkg::KEY_SECOND) begin
                        state_next = wdru_pkg::U_OPEN_UP;
                    end
                end
                wdru_pkg::U_OPEN_UP: begin
                    if (wr.upper) state_next = wdru_pkg::U_OPEN_MID;
                end
                wdru_pkg::U_OPEN_MID: begin
                    if (wr.middle) state_next = wdru_pkg::U_OPEN_LOW;
                end
                wdru_pkg::U_OPEN_LOW: begin
                    if (wr.low) state_next = wdru_pkg::U_LOCKED;
                end
                default: state_next = wdru_pkg::U_LOCKED;
            endcase
        end
    end

    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) state_reg <= wdru_pkg::U_LOCKED;
        else        state_reg <= state_next;
    end

    // one byte open at a time
    assign allow_upper  = (state_reg == wdru_pkg::U_OPEN_UP);
    assign allow_middle = (state_reg == wdru_pkg::U_OPEN_MID);
    assign allow_low    = (state_reg == wdru_pkg::U_OPEN_LOW);
endmodule
`default_nettype wire

// ==== core/wdru_counter.sv ====
// Purpose: 24-bit watchdog down-counter
// Assumes: tick is a one-cycle pulse per oscillator period
// Notes:   wraps from zero to all ones and keeps counting
`timescale 1ns/100ps
`default_nettype none
module wdru_counter #(
    parameter int CW = 24 // counter width
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst_n,
    // control
    input  wire logic          running,
    input  wire logic          start,
    input  wire logic          refresh,
    input  wire logic          tick,
    input  wire logic [CW-1:0] reload,
    // state
    output logic      [CW-1:0] count,
    output logic               timeout
);
    logic refresh_ok; // refresh still allowed

    assign refresh_ok = refresh && running && (count > wdru_pkg::REFRESH_FLOOR);

    // count update: first start, then refresh, then tick
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (start || refresh_ok) begin
            count <= reload;
        end else if (tick && running) begin
            count <= count - 1'b1;
        end
    end

    // one-cycle pulse as the count lands on zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) timeout <= 1'b0;
        else timeout <= tick && running && !start && !refresh_ok
                        && (count == wdru_pkg::COUNT_LAST);
    end
endmodule
`default_nettype wire

// ==== core/wdru_top.sv ====
// Purpose: watchdog reload registers, unlock gate and reset-cause register
// Assumes: Avalon-MM slave, byte address, only byte lane 0 carries data
// Notes:   every access is answered one cycle after it is presented
`timescale 1ns/100ps
`default_nettype none
module wdru_top (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [13:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // watchdog oscillator tick
    input  wire logic        osc_tick,
    // cpu refresh instruction
    input  wire logic        refresh_instr,
    // debugger active keeps refreshing
    input  wire logic        debug_mode,
    // option straps
    input  wire logic        timeout_response_option,
    input  wire logic        always_on_option,
    // time-out results and running flag
    output logic             timeout_irq,
    output logic             timeout_sys_reset,
    output logic             watchdog_running
);

    // address match against a register index
    function automatic logic hit(input logic [13:0] addr,
                                 input logic [11:0] idx);
        hit = (addr == {idx, 2'b00});
    endfunction

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------

    logic wait_reg;      // waitrequest flop
    logic take;          // request taken this edge
    logic rd_take;       // read taken
    logic wr_take;       // write taken, lane 0 enabled
    logic sel_key;       // key / reset-cause address
    logic sel_upper;     // upper reload byte
    logic sel_middle;    // middle reload byte
    logic sel_low;       // low reload byte

    // address decode
    assign sel_key    = hit(avs_address, wdru_pkg::IDX_KEY);
    assign sel_upper  = hit(avs_address, wdru_pkg::IDX_UPPER);
    assign sel_middle = hit(avs_address, wdru_pkg::IDX_MIDDLE);
    assign sel_low    = hit(avs_address, wdru_pkg::IDX_LOW);

    // a request is taken when waitrequest is still high
    assign take    = (avs_read || avs_write) && wait_reg;
    assign rd_take = take && avs_read;
    assign wr_take = take && avs_write && avs_byteenable[0];

    // waitrequest drops for one cycle per access
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= 1'b1;
        end else if (take) begin
            wait_reg <= 1'b0; // answer next cycle
        end else begin
            wait_reg <= 1'b1; // re-arm after answer
        end
    end

    assign avs_waitrequest = wait_reg;

    // ------------------------------------------------------------
    // decoded writes and the unlock sequencer
    // ------------------------------------------------------------

    wdru_pkg::wdru_wr_s wr;     // accepted write
    logic allow_upper;          // upper byte open
    logic allow_middle;         // middle byte open
    logic allow_low;            // low byte open

    // pack the accepted write for the sequencer
    always_comb begin
        wr.any    = wr_take;
        wr.key    = wr_take && sel_key;
        wr.upper  = wr_take && sel_upper;
        wr.middle = wr_take && sel_middle;
        wr.low    = wr_take && sel_low;
        wr.data   = avs_writedata[7:0];
    end

    // key sequence tracker
    wdru_unlock u_unlock (
        .clock        (clock),
        .rst_n        (rst_n),
        .wr           (wr),
        .allow_upper  (allow_upper),
        .allow_middle (allow_middle),
        .allow_low    (allow_low)
    );

    // ------------------------------------------------------------
    // reload bytes
    // ------------------------------------------------------------

    logic [7:0]  upper_reg;   // reload bits 23:16
    logic [7:0]  middle_reg;  // reload bits 15:8
    logic [7:0]  low_reg;     // reload bits 7:0
    logic [23:0] reload;      // joined reload value

    // upper byte, only while open
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            upper_reg <= wdru_pkg::RST_UPPER;
        end else if (wr.upper && allow_upper) begin
            upper_reg <= wr.data;
        end
    end

    // middle byte, only while open
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            middle_reg <= wdru_pkg::RST_MIDDLE;
        end else if (wr.middle && allow_middle) begin
            middle_reg <= wr.data;
        end
    end

    // low byte, only while open
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            low_reg <= wdru_pkg::RST_LOW;
        end else if (wr.low && allow_low) begin
            low_reg <= wr.data;
        end
    end

    // byte order of the reload value
    assign reload = {upper_reg, middle_reg, low_reg};

    // ------------------------------------------------------------
    // option straps, caught after reset release
    // ------------------------------------------------------------

    logic strap_done_reg;  // straps already sampled
    logic resp_irq_reg;    // time-out raises interrupt
    logic always_on_reg;   // start without refresh

    // sample straps on the first edge after release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_reg <= 1'b0;
            resp_irq_reg   <= 1'b0;
            always_on_reg  <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            resp_irq_reg   <= timeout_response_option;
            always_on_reg  <= always_on_option;
        end
    end

    // ------------------------------------------------------------
    // run control and counter
    // ------------------------------------------------------------

    logic        running_reg;  // counter enabled
    logic        start;        // first enable pulse
    logic        refresh;      // refresh request
    logic [23:0] count;        // live count
    logic        timeout;      // count reached zero

    // debugger holds the count off zero
    assign refresh = refresh_instr || debug_mode;

    // first refresh or always-on strap starts the count
    assign start = !running_reg && (refresh_instr || always_on_reg);

    // once running, the watchdog never stops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            running_reg <= 1'b0;
        end else if (start) begin
            running_reg <= 1'b1;
        end
    end

    // the down-counter itself
    wdru_counter #(
        .CW (24)
    ) u_counter (
        .clock   (clock),
        .rst_n   (rst_n),
        .running (running_reg),
        .start   (start),
        .refresh (refresh),
        .tick    (osc_tick),
        .reload  (reload),
        .count   (count),
        .timeout (timeout)
    );

    // ------------------------------------------------------------
    // time-out response
    // ------------------------------------------------------------

    logic irq_reg;    // interrupt request pulse
    logic sysrst_reg; // system reset request pulse

    // route the time-out by the response strap
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg    <= 1'b0;
            sysrst_reg <= 1'b0;
        end else begin
            irq_reg    <= timeout && resp_irq_reg;
            sysrst_reg <= timeout && !resp_irq_reg;
        end
    end

    assign timeout_irq       = irq_reg;
    assign timeout_sys_reset = sysrst_reg;

    // running state as an output flop
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) watchdog_running <= 1'b0;
        else        watchdog_running <= running_reg;
    end

    // ------------------------------------------------------------
    // reset-cause register, shares the key address
    // ------------------------------------------------------------

    logic [7:0] cause_reg;  // reset-cause bits
    logic [7:0] cause_next; // next value

    // read clears, a time-out in the same cycle still sets
    always_comb begin
        cause_next = cause_reg;
        if (rd_take && sel_key) begin
            cause_next = 8'h00;
        end
        if (timeout) begin
            cause_next[wdru_pkg::RC_WDT_BIT] = 1'b1;
        end
    end

    // power-on flag set by reset itself
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) cause_reg <= wdru_pkg::RC_RESET;
        else        cause_reg <= cause_next;
    end

    // ------------------------------------------------------------
    // coherent count reads
    // ------------------------------------------------------------

    logic [15:0] snap_reg;       // lower count bytes at upper read
    logic        snap_valid_reg; // snapshot pending

    // upper read freezes the lower bytes until low is read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            snap_reg       <= 16'h0000;
            snap_valid_reg <= 1'b0;
        end else if (rd_take && sel_upper) begin
            snap_reg       <= count[15:0];
            snap_valid_reg <= 1'b1;
        end else if (rd_take && sel_low) begin
            snap_valid_reg <= 1'b0; // sequence done
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------

    logic [7:0] rd_byte; // selected read byte

    // byte returned for the current address
    always_comb begin
        rd_byte = 8'h00; // unmapped reads zero
        if (sel_key) begin
            rd_byte = cause_reg;
        end else if (sel_upper) begin
            rd_byte = count[23:16];
        end else if (sel_middle) begin
            rd_byte = snap_valid_reg ? snap_reg[15:8] : count[15:8];
        end else if (sel_low) begin
            rd_byte = snap_valid_reg ? snap_reg[7:0] : count[7:0];
        end
    end

    // read data latched with the answer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_take) begin
            avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

endmodule
`default_nettype wire

// ==== testbench/wdru_top_assertions.sv ====
// Purpose: port-level checks of the watchdog reload block
// Assumes: straps stay constant while out of reset
// Notes:   attached to wdru_top by the bind at the foot
`timescale 1ns/100ps
`default_nettype none
module wdru_top_chk (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // avalon-mm slave
    input wire logic [13:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // watchdog side
    input wire logic        osc_tick,
    input wire logic        timeout_response_option,
    input wire logic        timeout_irq,
    input wire logic        timeout_sys_reset,
    input wire logic        watchdog_running
);
    // byte address of the shared key / reset-cause slot
    localparam logic [13:0] KEY_ADDR = {wdru_pkg::IDX_KEY, 2'b00};

    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // access taken by the slave
    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    // read taken at the key address
    sequence s_rd_key;
        avs_read && avs_waitrequest && (avs_address == KEY_ADDR);
    endsequence

    ack_next_a: assert property (s_taken |=> !avs_waitrequest)
        else $error("access not answered in the next cycle");
    ack_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    idle_no_ack_a: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without a request");
    key_read_a: assert property (s_rd_key |=> (avs_readdata & 32'hffff_ff5f) == 32'h0)
        else $error("key address read shows more than reset-cause bits");
    byte_only_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data above byte lane 0");
    tick_cause_a: assert property (timeout_irq |-> $past(osc_tick, 2))
        else $error("time-out not two cycles after a tick");
    irq_pulse_a: assert property (timeout_irq |=> !timeout_irq)
        else $error("time-out interrupt longer than one cycle");
    irq_select_a: assert property (timeout_irq |-> timeout_response_option)
        else $error("interrupt raised with reset response chosen");
    rst_select_a: assert property (timeout_sys_reset |-> !timeout_response_option)
        else $error("system reset raised with interrupt response chosen");
    run_hold_a: assert property (watchdog_running |=> watchdog_running)
        else $error("running watchdog stopped");
endmodule
bind wdru_top wdru_top_chk u_chk (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .osc_tick(osc_tick), .timeout_response_option(timeout_response_option),
    .timeout_irq(timeout_irq), .timeout_sys_reset(timeout_sys_reset),
    .watchdog_running(watchdog_running)
);
`default_nettype wire

// ==== testbench/wdru_top_tb.sv ====
// Purpose: self-checking bench for the watchdog reload block
// Assumes: straps change only while reset is held
// Notes:   every register access goes through one avalon task
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        n_checks++; \
        if ((got) !== (ex)) begin \
            err_total++; \
            $display("[ERR] %s expected %h seen %h", nm, ex, got); \
        end \
    end
module wdru_top_tb;
    // byte addresses of the four registers, plus a spare one
    localparam logic [13:0] A_KEY = {wdru_pkg::IDX_KEY, 2'b00};
    localparam logic [13:0] A_UP  = {wdru_pkg::IDX_UPPER, 2'b00};
    localparam logic [13:0] A_MID = {wdru_pkg::IDX_MIDDLE, 2'b00};
    localparam logic [13:0] A_LOW = {wdru_pkg::IDX_LOW, 2'b00};
    localparam logic [13:0] A_OFF = 14'h3fd0;
    // dut signals
    logic        clock         = 1'b0;
    logic        rst_n         = 1'b0;
    logic [13:0] avs_address   = 14'h0;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        osc_tick      = 1'b0;
    logic        refresh_instr = 1'b0;
    logic        dbg           = 1'b0; // debugger active
    logic        resp_opt      = 1'b1; // strap: interrupt response
    logic        aon_opt       = 1'b0; // strap: always-on start
    logic        timeout_irq;
    logic        timeout_sys_reset;
    logic        watchdog_running;
    // bench state
    int          err_total     = 0;
    int          n_checks      = 0;
    logic [15:0] lfsr          = 16'h55ea;
    logic [23:0] rl;
    logic [7:0]  b;

    wdru_top u_dut (
        .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .osc_tick(osc_tick), .refresh_instr(refresh_instr), .debug_mode(dbg),
        .timeout_response_option(resp_opt), .always_on_option(aon_opt),
        .timeout_irq(timeout_irq), .timeout_sys_reset(timeout_sys_reset),
        .watchdog_running(watchdog_running)
    );

    // 125 MHz clock
    always #4 clock = ~clock;

    // next random value
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // software never sets a reload under the minimum
    function automatic logic [23:0] legal(input logic [23:0] r);
        return (r < wdru_pkg::RELOAD_MIN) ? wdru_pkg::RELOAD_MIN : r;
    endfunction

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [13:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clock);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= {24'h0, d};
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        q = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, a, d, x);
    endtask
    // one-cycle pulse: tick when t is set, refresh otherwise
    task automatic pulse(input logic t);
        @(posedge clock);
        if (t) osc_tick <= 1'b1;
        else refresh_instr <= 1'b1;
        @(posedge clock);
        osc_tick      <= 1'b0;
        refresh_instr <= 1'b0;
    endtask
    // full key sequence and reload write
    task automatic prog(input logic [23:0] r);
        wr(A_KEY, wdru_pkg::KEY_FIRST);
        wr(A_KEY, wdru_pkg::KEY_SECOND);
        wr(A_UP, r[23:16]);
        wr(A_MID, r[15:8]);
        wr(A_LOW, r[7:0]);
    endtask
    // read the live count, upper byte first
    task automatic chk_count(input logic [23:0] ex);
        bus(1'b0, A_UP, 8'h0, b);
        `CHK("count upper", ex[23:16], b);
        bus(1'b0, A_MID, 8'h0, b);
        `CHK("count middle", ex[15:8], b);
        bus(1'b0, A_LOW, 8'h0, b);
        `CHK("count low", ex[7:0], b);
    endtask

    // verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // hang guard, far beyond the expected run
    initial begin
        #200000;
        err_total++;
        end_sim();
    end

    // main sequence
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        // reset cause, write-only key, count before start
        bus(1'b0, A_KEY, 8'h0, b);
        `CHK("cause after reset", wdru_pkg::RC_RESET, b);
        bus(1'b0, A_KEY, 8'h0, b);
        `CHK("cause cleared", 8'h00, b);
        wr(A_KEY, 8'h5a);
        bus(1'b0, A_KEY, 8'h0, b);
        `CHK("key not readable", 8'h00, b);
        chk_count(24'h0);
        $display("test reset done");
        // unlock, program, refresh, read back; corners then random
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            rl = {lfsr, 8'h0};
            lfsr = lfsr_next(lfsr);
            rl = legal({rl[23:8], lfsr[7:0]});
            if (i == 0) rl = 24'hff_ffff;
            if (i == 1) rl = wdru_pkg::RELOAD_MIN;
            prog(rl);
            pulse(1'b0);
            // running flag trails the start edge by two flops
            repeat (2) @(posedge clock);
            `CHK("running", 1'b1, watchdog_running);
            chk_count(rl);
        end
        $display("test reload done");
        // locked write ignored, relock after low byte
        wr(A_UP, ~rl[23:16]);
        pulse(1'b0);
        chk_count(rl);
        // stray write in mid-sequence relocks
        wr(A_KEY, wdru_pkg::KEY_FIRST);
        wr(A_KEY, wdru_pkg::KEY_SECOND);
        wr(A_UP, 8'h3c);
        wr(A_OFF, 8'h11);
        wr(A_MID, 8'h99);
        wr(A_LOW, 8'h77);
        pulse(1'b0);
        bus(1'b0, A_UP, 8'h0, b);
        `CHK("upper taken", 8'h3c, b);
        bus(1'b0, A_MID, 8'h0, b);
        `CHK("middle refused", rl[15:8], b);
        bus(1'b0, A_LOW, 8'h0, b);
        `CHK("low refused", rl[7:0], b);
        $display("test lock done");
        // countdown, refresh floor, time-out and wrap
        prog(wdru_pkg::RELOAD_MIN);
        pulse(1'b0);
        pulse(1'b1);
        pulse(1'b1);
        chk_count(24'h00_0002);
        pulse(1'b0);
        chk_count(24'h00_0002);
        pulse(1'b1);
        pulse(1'b1);
        for (int n = 0; n < 8 && timeout_irq !== 1'b1; n++) @(posedge clock);
        `CHK("time-out irq", 1'b1, timeout_irq);
        `CHK("no system reset", 1'b0, timeout_sys_reset);
        // count sits at zero until the next tick wraps it
        pulse(1'b1);
        chk_count(24'hff_ffff);
        bus(1'b0, A_KEY, 8'h0, b);
        `CHK("cause after time-out", 8'h01 << wdru_pkg::RC_WDT_BIT, b);
        $display("test timeout done");
        // second reset: reset response, always-on start, debug hold
        rst_n    <= 1'b0;
        resp_opt <= 1'b0;
        aon_opt  <= 1'b1;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK("always-on running", 1'b1, watchdog_running);
        rl = {wdru_pkg::RST_UPPER, wdru_pkg::RST_MIDDLE, wdru_pkg::RST_LOW};
        chk_count(rl);
        dbg <= 1'b1;
        pulse(1'b1);
        pulse(1'b1);
        dbg <= 1'b0;
        chk_count(rl);
        prog(wdru_pkg::RELOAD_MIN);
        pulse(1'b0);
        repeat (4) pulse(1'b1);
        for (int n = 0; n < 8 && timeout_sys_reset !== 1'b1; n++) @(posedge clock);
        `CHK("time-out reset", 1'b1, timeout_sys_reset);
        `CHK("no irq", 1'b0, timeout_irq);
        bus(1'b0, A_KEY, 8'h0, b);
        `CHK("cause rst", wdru_pkg::RC_RESET | (8'h01 << wdru_pkg::RC_WDT_BIT), b);
        $display("test reset response done");
        end_sim();
    end
endmodule
`default_nettype wire
